// *** verilog/lhbp_pkg.sv ***
package lhbp_pkg;

    // bus styles selected by the two straps {strap_b, strap_a}
    localparam logic [1:0] STYLE_STROBE_PAIR = 2'h0;

    // commands (host writes these with command_data_select high)
    localparam logic [7:0] CMD_SYSTEM_SET    = 8'h40;
    localparam logic [7:0] CMD_SLEEP_IN      = 8'h53;
    localparam logic [7:0] CMD_DISP_ON_OFF   = 8'h58;
    localparam logic [7:0] CMD_CURSOR_DIR    = 8'h4C;
    localparam logic [7:0] CMD_CURSOR_WRITE  = 8'h46;
    localparam logic [7:0] CMD_CURSOR_READ   = 8'h47;
    localparam logic [7:0] CMD_MEM_WRITE     = 8'h42;
    localparam logic [7:0] CMD_MEM_READ      = 8'h43;
    localparam logic [1:0] CMD_DIR_MASK_LSB  = 2'h3;

    // status byte layout
    localparam int         STATUS_BIT        = 6;

    // display memory geometry
    localparam int         VRAM_AW           = 16;
    localparam int         DATA_W            = 8;
    localparam int         FIFO_DEPTH        = 32;

    // cursor step per direction code: right, left, up, down
    localparam logic [1:0] DIR_RIGHT         = 2'h0;
    localparam logic [1:0] DIR_LEFT          = 2'h1;
    localparam logic [1:0] DIR_UP            = 2'h2;
    localparam logic [1:0] DIR_DOWN          = 2'h3;
    localparam logic [15:0] ROW_STEP_RESET   = 16'h0028;
    localparam logic [15:0] ONE_STEP         = 16'h0001;

    // cursor register byte selectors
    localparam logic        BYTE_LOW         = 1'b0;
    localparam logic        BYTE_HIGH        = 1'b1;

    typedef enum logic [2:0] {
        LHBP_IDLE_type_s    = 3'b000,
        LHBP_WRITE_s        = 3'b001,
        LHBP_READ_s         = 3'b011,
        LHBP_CURSOR_s       = 3'b010,
        LHBP_DIR_s          = 3'b110,
        LHBP_SYS_s          = 3'b111,
        LHBP_CURRD_s        = 3'b101
    } lhbp_mode_type;

endpackage

// *** verilog/lhbp_fifo.sv ***
`timescale 1ns/100ps
module lhbp_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // filling side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // draining side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr_r;
    logic [AW:0]      rd_ptr_r;
    wire              full;
    wire              empty;
    wire              push;
    wire              pop;

    assign full        = (wr_ptr_r[AW] != rd_ptr_r[AW])
                      && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    assign empty       = (wr_ptr_r == rd_ptr_r);
    assign in_ready_o  = !full;
    assign out_valid_o = !empty;
    assign push        = in_valid_i && !full;
    assign pop         = out_ready_i && !empty;
    assign out_data_o  = mem[rd_ptr_r[AW-1:0]];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_r[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_r + (AW+1)'(push);
            rd_ptr_r <= rd_ptr_r + (AW+1)'(pop);
        end
    end
endmodule

// *** verilog/lhbp_port.sv ***
`timescale 1ns/100ps
// How it works
// - strobe-pair style: select and strobes pick status, data or command
// - direction-plus-enable style: read pin is direction, write pin enable
// - two strap inputs choose which bus style decodes the pins
// - every access completes in one bus cycle, no busy handshake
// - status read drives retrace flag on data bit 6
// - while asleep only system-setup and sleep-enter commands are accepted
// - memory-write command, then data bytes buffered toward display memory
// - memory-read command prefetches first byte into output buffer
// - each data read in memory-read mode prefetches the following byte
module lhbp_port (
    // clock and reset
    input  wire logic        CLOCK_I,
    input  wire logic        RST_N_I,
    // bus style straps
    input  wire logic        BUS_STYLE_STRAP_A_I,
    input  wire logic        BUS_STYLE_STRAP_B_I,
    // host bus control pins
    input  wire logic        CHIP_SELECT_N_I,
    input  wire logic        COMMAND_DATA_SELECT_I,
    input  wire logic        READ_N_I,
    input  wire logic        WRITE_N_I,
    // host data bus
    input  wire logic [7:0]  DATA_I,
    output logic      [7:0]  DATA_O,
    output logic             DATA_OE_O,
    // display state
    input  wire logic        RETRACE_I,
    output logic             SLEEP_O,
    // display memory write side
    output logic             VRAM_WR_VALID_O,
    input  wire logic        VRAM_WR_READY_I,
    output logic      [15:0] VRAM_WR_ADDR_O,
    output logic      [7:0]  VRAM_WR_DATA_O,
    // display memory read side
    output logic             VRAM_RD_REQ_O,
    output logic      [15:0] VRAM_RD_ADDR_O,
    input  wire logic        VRAM_RD_VALID_I,
    input  wire logic [7:0]  VRAM_RD_DATA_I
);
    localparam int FW = lhbp_pkg::VRAM_AW + lhbp_pkg::DATA_W;

    // reset release and pin synchronisers
    logic [1:0] rst_sync_r;
    wire        rst_n;
    logic [4:0] pin_meta_r;
    logic [4:0] pin_r;
    logic [7:0] data_meta_r;
    logic [7:0] data_r;
    logic       ret_meta_r;
    logic       ret_r;
    logic [1:0] strap_r;
    logic       strap_done_r;
    logic [1:0] strap_wait_r;

    assign rst_n = rst_sync_r[1];

    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    // pins idle high so reset them to the inactive state
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_r  <= 5'h1F;
            pin_r       <= 5'h1F;
            data_meta_r <= 8'h00;
            data_r      <= 8'h00;
            ret_meta_r  <= 1'b0;
            ret_r       <= 1'b0;
        end else begin
            pin_meta_r  <= {BUS_STYLE_STRAP_B_I, BUS_STYLE_STRAP_A_I,
                            CHIP_SELECT_N_I, READ_N_I, WRITE_N_I};
            pin_r       <= pin_meta_r;
            data_meta_r <= DATA_I;
            data_r      <= data_meta_r;
            ret_meta_r  <= RETRACE_I;
            ret_r       <= ret_meta_r;
        end
    end

    // the synchroniser needs two edges after release before pin_r holds
    // the real strap levels; earlier it still shows its reset value
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            strap_wait_r <= 2'h0;
        end else begin
            strap_wait_r <= {strap_wait_r[0], 1'b1};
        end
    end

    // straps caught once, then held for the whole run
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            strap_r      <= 2'h0;
            strap_done_r <= 1'b0;
        end else if (strap_wait_r[1] && !strap_done_r) begin
            strap_r      <= pin_r[4:3];
            strap_done_r <= 1'b1;
        end
    end

    // command/data select is sampled beside the strobes
    logic a0_meta_r;
    logic a0_r;
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            a0_meta_r <= 1'b0;
            a0_r      <= 1'b0;
        end else begin
            a0_meta_r <= COMMAND_DATA_SELECT_I;
            a0_r      <= a0_meta_r;
        end
    end

    wire strobe_pair = (strap_r == lhbp_pkg::STYLE_STROBE_PAIR);
    wire cs_act      = !pin_r[2];
    wire rd_sp       = cs_act && !pin_r[1] && pin_r[0];
    wire wr_sp       = cs_act && pin_r[1] && !pin_r[0];
    // direction-plus-enable decode
    // the write pin stays high as enable, so chip select times the access
    wire rd_de       = cs_act && pin_r[1] && pin_r[0];
    wire wr_de       = cs_act && !pin_r[1] && pin_r[0];
    wire rd_act      = strobe_pair ? rd_sp : rd_de;
    wire wr_act      = strobe_pair ? wr_sp : wr_de;

    logic rd_prev_r;
    logic wr_prev_r;
    wire  rd_end     = rd_prev_r && !rd_act;
    wire  wr_start   = wr_act && !wr_prev_r;

    wire  cmd_wr     = wr_start && a0_r;
    wire  par_wr     = wr_start && !a0_r;
    wire  data_rd    = rd_end && a0_r;

    // command and parameter state
    lhbp_pkg::lhbp_mode_type mode_r;
    logic        sleep_r;
    logic [1:0]  dir_r;
    logic [15:0] cursor_r;
    logic        byte_sel_r;
    logic [15:0] row_step_r;
    logic [7:0]  rd_buf_r;
    logic        fetch_r;
    logic [15:0] fetch_addr_r;

    wire sleep_ok = (data_r == lhbp_pkg::CMD_SYSTEM_SET)
                 || (data_r == lhbp_pkg::CMD_SLEEP_IN);
    wire cmd_take = cmd_wr && (!sleep_r || sleep_ok);

    function automatic logic [15:0] step_cursor(input logic [15:0] a,
                                                input logic [1:0]  d,
                                                input logic [15:0] row);
        unique case (d)
            lhbp_pkg::DIR_RIGHT: step_cursor = a + lhbp_pkg::ONE_STEP;
            lhbp_pkg::DIR_LEFT:  step_cursor = a - lhbp_pkg::ONE_STEP;
            lhbp_pkg::DIR_UP:    step_cursor = a - row;
            lhbp_pkg::DIR_DOWN:  step_cursor = a + row;
        endcase
    endfunction

    wire        fifo_in_ready;
    wire        wr_data = par_wr && (mode_r == lhbp_pkg::LHBP_WRITE_s);
    wire        rd_data = data_rd && (mode_r == lhbp_pkg::LHBP_READ_s);
    wire [15:0] cursor_next = step_cursor(cursor_r, dir_r, row_step_r);

    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            rd_prev_r  <= 1'b0;
            wr_prev_r  <= 1'b0;
            mode_r     <= lhbp_pkg::LHBP_IDLE_type_s;
            sleep_r    <= 1'b0;
            dir_r      <= lhbp_pkg::DIR_RIGHT;
            cursor_r   <= 16'h0000;
            byte_sel_r <= lhbp_pkg::BYTE_LOW;
            row_step_r <= lhbp_pkg::ROW_STEP_RESET;
            fetch_r    <= 1'b0;
            fetch_addr_r <= 16'h0000;
        end else begin
            rd_prev_r <= rd_act;
            wr_prev_r <= wr_act;
            fetch_r   <= 1'b0;
            // command acts in the strobe cycle
            if (cmd_take) begin
                byte_sel_r <= lhbp_pkg::BYTE_LOW;
                unique case (data_r)
                    lhbp_pkg::CMD_SYSTEM_SET: begin
                        sleep_r <= 1'b0;
                        mode_r  <= lhbp_pkg::LHBP_SYS_s;
                    end
                    lhbp_pkg::CMD_SLEEP_IN: begin
                        sleep_r <= 1'b1;
                        mode_r  <= lhbp_pkg::LHBP_IDLE_type_s;
                    end
                    lhbp_pkg::CMD_MEM_WRITE:
                        mode_r <= lhbp_pkg::LHBP_WRITE_s;
                    lhbp_pkg::CMD_MEM_READ: begin
                        mode_r       <= lhbp_pkg::LHBP_READ_s;
                        fetch_r      <= 1'b1;
                        fetch_addr_r <= cursor_r;
                    end
                    lhbp_pkg::CMD_CURSOR_WRITE:
                        mode_r <= lhbp_pkg::LHBP_CURSOR_s;
                    lhbp_pkg::CMD_CURSOR_READ:
                        mode_r <= lhbp_pkg::LHBP_CURRD_s;
                    default: begin
                        if (data_r[7:2] == lhbp_pkg::CMD_CURSOR_DIR[7:2]) begin
                            dir_r  <= data_r[1:0];
                            mode_r <= lhbp_pkg::LHBP_DIR_s;
                        end else begin
                            mode_r <= lhbp_pkg::LHBP_IDLE_type_s;
                        end
                    end
                endcase
            end else if (par_wr
                      && mode_r == lhbp_pkg::LHBP_CURSOR_s) begin
                if (byte_sel_r == lhbp_pkg::BYTE_LOW) begin
                    cursor_r[7:0] <= data_r;
                end else begin
                    cursor_r[15:8] <= data_r;
                end
                byte_sel_r <= !byte_sel_r;
            end else if (par_wr && mode_r == lhbp_pkg::LHBP_SYS_s) begin
                // the byte-per-row figure arrives as a setup parameter
                row_step_r <= {8'h00, data_r} + lhbp_pkg::ONE_STEP;
            end else if (wr_data && fifo_in_ready) begin
                cursor_r <= cursor_next;
            end else if (rd_data) begin
                cursor_r     <= cursor_next;
                fetch_r      <= 1'b1;
                fetch_addr_r <= cursor_next;
            end else if (data_rd
                      && mode_r == lhbp_pkg::LHBP_CURRD_s) begin
                byte_sel_r <= !byte_sel_r;
            end
        end
    end

    // read buffer fills from display memory answer
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            rd_buf_r <= 8'h00;
        end else if (VRAM_RD_VALID_I) begin
            rd_buf_r <= VRAM_RD_DATA_I;
        end
    end

    // write buffer toward slow display memory
    // a full buffer drops the byte, host must pace bursts above 32 bytes
    lhbp_fifo #(
        .WIDTH (FW),
        .DEPTH (lhbp_pkg::FIFO_DEPTH)
    ) u_wr_fifo (
        .clk_i       (CLOCK_I),
        .rst_n_i     (rst_n),
        .in_valid_i  (wr_data),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   ({cursor_r, data_r}),
        .out_valid_o (VRAM_WR_VALID_O),
        .out_ready_i (VRAM_WR_READY_I),
        .out_data_o  ({VRAM_WR_ADDR_O, VRAM_WR_DATA_O})
    );

    // output data mux
    wire [7:0] cur_byte = (byte_sel_r == lhbp_pkg::BYTE_LOW)
                        ? cursor_r[7:0] : cursor_r[15:8];
    wire [7:0] status_byte = 8'(ret_r) << lhbp_pkg::STATUS_BIT;
    wire [7:0] data_byte   = (mode_r == lhbp_pkg::LHBP_CURRD_s)
                           ? cur_byte : rd_buf_r;
    wire [7:0] read_byte   = a0_r ? data_byte : status_byte;
    logic [7:0] dout_r;
    logic       doe_r;

    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            dout_r <= 8'h00;
            doe_r  <= 1'b0;
        end else begin
            dout_r <= read_byte;
            doe_r  <= rd_act;
        end
    end

    assign DATA_O         = dout_r;
    assign DATA_OE_O      = doe_r;
    assign SLEEP_O        = sleep_r;
    assign VRAM_RD_REQ_O  = fetch_r;
    assign VRAM_RD_ADDR_O = fetch_addr_r;
endmodule

// *** sim/lhbp_port_monitor.sv ***
`timescale 1ns/100ps
module lhbp_port_monitor (
    // clock and straps
    input wire logic        CLOCK_I,
    input wire logic        RST_N_I,
    input wire logic        BUS_STYLE_STRAP_A_I,
    input wire logic        BUS_STYLE_STRAP_B_I,
    // host pins
    input wire logic        CHIP_SELECT_N_I,
    input wire logic        COMMAND_DATA_SELECT_I,
    input wire logic        READ_N_I,
    input wire logic        WRITE_N_I,
    input wire logic [7:0]  DATA_I,
    input wire logic [7:0]  DATA_O,
    input wire logic        DATA_OE_O,
    input wire logic        RETRACE_I,
    input wire logic        SLEEP_O,
    // display memory
    input wire logic        VRAM_WR_VALID_O,
    input wire logic        VRAM_WR_READY_I,
    input wire logic [15:0] VRAM_WR_ADDR_O,
    input wire logic [7:0]  VRAM_WR_DATA_O,
    input wire logic        VRAM_RD_REQ_O
);
    // straps only move under reset, so the live value is safe here
    wire alt    = BUS_STYLE_STRAP_A_I | BUS_STYLE_STRAP_B_I;
    wire sel    = !CHIP_SELECT_N_I;
    wire rd     = sel & (alt ? READ_N_I & WRITE_N_I : !READ_N_I);
    wire wr     = sel & (alt ? !READ_N_I & WRITE_N_I : !WRITE_N_I);
    wire st_rd  = rd & !COMMAND_DATA_SELECT_I;
    wire dt_rd  = rd & COMMAND_DATA_SELECT_I;
    wire cmd_wr = wr & COMMAND_DATA_SELECT_I;
    wire rd_cmd = cmd_wr & (DATA_I == lhbp_pkg::CMD_MEM_READ);

    // only data reads inside an open display read must fetch again
    logic rd_mode_r;
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            rd_mode_r <= 1'b0;
        end else if (cmd_wr && !SLEEP_O) begin
            rd_mode_r <= (DATA_I == lhbp_pkg::CMD_MEM_READ);
        end
    end

    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (!RST_N_I);

    AST_OE_CAUSE:
        assert property ($rose(DATA_OE_O) |-> $past(rd, 3))
        else $error("bus driven without a read");
    AST_OE_OFF:
        assert property (!rd [*4] |-> !DATA_OE_O)
        else $error("bus still driven after read");
    AST_STATUS:
        assert property (DATA_OE_O && $past(st_rd, 3)
            |-> DATA_O[6] == $past(RETRACE_I, 3))
        else $error("status bit wrong");
    AST_WR_HOLD:
        assert property (VRAM_WR_VALID_O && !VRAM_WR_READY_I
            |=> VRAM_WR_VALID_O && $stable(VRAM_WR_ADDR_O)
            && $stable(VRAM_WR_DATA_O))
        else $error("write stream dropped while stalled");
    AST_PREFETCH:
        assert property ($fell(dt_rd) && rd_mode_r
            |-> ##[1:6] VRAM_RD_REQ_O)
        else $error("no fetch after data read");
    AST_MEMORY_READ_COMMAND:
        assert property (!SLEEP_O && $rose(rd_cmd)
            |-> ##[1:5] VRAM_RD_REQ_O)
        else $error("no fetch after read command");
    AST_SLEEP_IN:
        assert property ($rose(SLEEP_O) |-> $past(cmd_wr)
            && $past(DATA_I) == lhbp_pkg::CMD_SLEEP_IN)
        else $error("sleep entered without command");
    AST_SLEEP_REFUSE:
        assert property (SLEEP_O && $rose(rd_cmd) |-> !VRAM_RD_REQ_O [*6])
        else $error("read command taken in sleep");
endmodule

bind lhbp_port lhbp_port_monitor mon (
    .CLOCK_I, .RST_N_I, .BUS_STYLE_STRAP_A_I, .BUS_STYLE_STRAP_B_I,
    .CHIP_SELECT_N_I, .COMMAND_DATA_SELECT_I, .READ_N_I, .WRITE_N_I,
    .DATA_I, .DATA_O, .DATA_OE_O, .RETRACE_I, .SLEEP_O,
    .VRAM_WR_VALID_O, .VRAM_WR_READY_I, .VRAM_WR_ADDR_O,
    .VRAM_WR_DATA_O, .VRAM_RD_REQ_O
);

// *** sim/lhbp_vram_model.sv ***
`timescale 1ns/100ps
module lhbp_vram_model (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // slow mode stalls writes and answers reads late
    input  wire logic        slow_i,
    // write stream
    input  wire logic        wr_valid_i,
    output logic             wr_ready_o,
    input  wire logic [15:0] wr_addr_i,
    input  wire logic [7:0]  wr_data_i,
    // read request and answer
    input  wire logic        rd_req_i,
    input  wire logic [15:0] rd_addr_i,
    output logic             rd_valid_o,
    output logic      [7:0]  rd_data_o
);
    logic [7:0]  mem [0:65535];
    int          n_wr = 0;
    logic [15:0] addr_r;
    logic [2:0]  wait_r;
    assign wr_ready_o = !slow_i;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_valid_o <= 1'b0;
            rd_data_o  <= 8'h00;
            wait_r     <= 3'h0;
            addr_r     <= 16'h0000;
        end else begin
            rd_valid_o <= 1'b0;
            // data lines are not held between answers
            rd_data_o  <= ~rd_data_o;
            if (wr_valid_i && wr_ready_o) begin
                mem[wr_addr_i] <= wr_data_i;
                n_wr <= n_wr + 1;
            end
            if (rd_req_i) begin
                addr_r <= rd_addr_i;
                wait_r <= slow_i ? 3'h4 : 3'h1;
            end else if (wait_r != 3'h0) begin
                wait_r <= wait_r - 3'h1;
            end
            if (!rd_req_i && wait_r == 3'h1) begin
                rd_valid_o <= 1'b1;
                rd_data_o  <= mem[addr_r];
            end
        end
    end
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        strap_a = 1'b0;
    logic        strap_b = 1'b0;
    logic        cs_n = 1'b1;
    logic        cdsel = 1'b0;
    logic        rd_n = 1'b1;
    logic        wr_n = 1'b1;
    logic [7:0]  dout = 8'h00;
    logic        retrace = 1'b0;
    logic        slow = 1'b0;
    logic        style = 1'b0;
    logic [7:0]  rdata;
    wire  [7:0]  data_bus, data_o, wr_data, rd_data;
    wire  [15:0] wr_addr, rd_addr;
    wire         oe, sleep, wr_valid, wr_ready, rd_req, rd_valid;
    int          failures = 0;
    int          samples_checked = 0;

    always #2.5 clk = ~clk;
    assign data_bus = oe ? data_o : dout;

    lhbp_port dut (
        .CLOCK_I(clk), .RST_N_I(rst_n),
        .BUS_STYLE_STRAP_A_I(strap_a), .BUS_STYLE_STRAP_B_I(strap_b),
        .CHIP_SELECT_N_I(cs_n), .COMMAND_DATA_SELECT_I(cdsel),
        .READ_N_I(rd_n), .WRITE_N_I(wr_n), .DATA_I(data_bus),
        .DATA_O(data_o), .DATA_OE_O(oe), .RETRACE_I(retrace),
        .SLEEP_O(sleep), .VRAM_WR_VALID_O(wr_valid),
        .VRAM_WR_READY_I(wr_ready), .VRAM_WR_ADDR_O(wr_addr),
        .VRAM_WR_DATA_O(wr_data), .VRAM_RD_REQ_O(rd_req),
        .VRAM_RD_ADDR_O(rd_addr), .VRAM_RD_VALID_I(rd_valid),
        .VRAM_RD_DATA_I(rd_data));
    lhbp_vram_model vram (
        .clk_i(clk), .rst_n_i(rst_n), .slow_i(slow),
        .wr_valid_i(wr_valid), .wr_ready_o(wr_ready),
        .wr_addr_i(wr_addr), .wr_data_i(wr_data), .rd_req_i(rd_req),
        .rd_addr_i(rd_addr), .rd_valid_o(rd_valid), .rd_data_o(rd_data));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    // one access held six edges; idle gap lets the prefetch land
    task automatic acc(input logic wr, input logic cd, input logic [7:0] d);
        @(posedge clk);
        cs_n  <= 1'b0;
        cdsel <= cd;
        dout  <= d;
        rd_n  <= style ? !wr : wr;
        wr_n  <= style ? 1'b1 : !wr;
        repeat (6) @(posedge clk);
        rdata = data_o;
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        dout <= ~d;
        repeat (12) @(posedge clk);
    endtask

    task automatic cmd(input logic [7:0] c);
        acc(1'b1, 1'b1, c);
    endtask
    task automatic prm(input logic [7:0] p);
        acc(1'b1, 1'b0, p);
    endtask
    task automatic cursor(input logic [15:0] a);
        cmd(lhbp_pkg::CMD_CURSOR_WRITE);
        prm(a[7:0]);
        prm(a[15:8]);
    endtask

    task automatic t_status();
        for (int r = 0; r < 2; r++) begin
            retrace <= 1'(r);
            acc(1'b0, 1'b0, 8'h00);
            check(16'(rdata[6]), 16'(r));
        end
        $display("test status done");
    endtask

    task automatic t_dirs();
        logic [15:0] nxt [4];
        nxt = '{16'h1000 + lhbp_pkg::ONE_STEP, 16'h1000 - lhbp_pkg::ONE_STEP,
                16'h1000 - lhbp_pkg::ROW_STEP_RESET,
                16'h1000 + lhbp_pkg::ROW_STEP_RESET};
        for (int d = 0; d < 4; d++) begin
            cmd(lhbp_pkg::CMD_CURSOR_DIR | 8'(d));
            cursor(16'h1000);
            cmd(lhbp_pkg::CMD_MEM_WRITE);
            prm(8'h10 + 8'(d));
            prm(8'h20 + 8'(d));
            check(16'(vram.mem[16'h1000]), 16'h0010 + 16'(d));
            check(16'(vram.mem[nxt[d]]), 16'h0020 + 16'(d));
        end
        $display("test directions done");
    endtask

    task automatic t_read();
        cmd(lhbp_pkg::CMD_CURSOR_DIR);
        cursor(16'h0400);
        cmd(lhbp_pkg::CMD_MEM_WRITE);
        for (int i = 0; i < 4; i++) prm(8'h50 + 8'(i));
        slow <= 1'b1;
        cursor(16'h0400);
        cmd(lhbp_pkg::CMD_MEM_READ);
        for (int i = 0; i < 4; i++) begin
            acc(1'b0, 1'b1, 8'h00);
            check(16'(rdata), 16'h0050 + 16'(i));
        end
        slow <= 1'b0;
        $display("test read done");
    endtask

    task automatic t_fifo();
        int n0;
        slow <= 1'b1;
        cursor(16'h0800);
        cmd(lhbp_pkg::CMD_MEM_WRITE);
        n0 = vram.n_wr;
        for (int i = 0; i < 34; i++) prm(8'(i));
        #1 check(16'(wr_valid), 16'h0001);
        @(posedge clk);
        slow <= 1'b0;
        for (int k = 0; k < 200 && wr_valid !== 1'b0; k++) @(posedge clk);
        #1 check(16'(wr_valid), 16'h0000);
        check(16'(vram.n_wr - n0), 16'(lhbp_pkg::FIFO_DEPTH));
        check(16'(vram.mem[16'h081F]), 16'h001F);
        $display("test buffer done");
    endtask

    task automatic t_sleep();
        cmd(lhbp_pkg::CMD_SLEEP_IN);
        check(16'(sleep), 16'h0001);
        cmd(lhbp_pkg::CMD_CURSOR_DIR | 8'(lhbp_pkg::DIR_DOWN));
        cmd(lhbp_pkg::CMD_MEM_READ);
        check(16'(sleep), 16'h0001);
        cmd(lhbp_pkg::CMD_SYSTEM_SET);
        prm(8'h0F);
        check(16'(sleep), 16'h0000);
        cursor(16'h2000);
        cmd(lhbp_pkg::CMD_MEM_WRITE);
        prm(8'hAA);
        prm(8'hBB);
        check(16'(vram.mem[16'h2001]), 16'h00BB);
        cmd(lhbp_pkg::CMD_CURSOR_DIR | 8'(lhbp_pkg::DIR_DOWN));
        cursor(16'h2100);
        cmd(lhbp_pkg::CMD_MEM_WRITE);
        prm(8'hCC);
        prm(8'hDD);
        check(16'(vram.mem[16'h2110]), 16'h00DD);
        // cursor now two rows below 2100h, read back low then high
        cmd(lhbp_pkg::CMD_CURSOR_READ);
        acc(1'b0, 1'b1, 8'h00);
        check(16'(rdata), 16'h0020);
        acc(1'b0, 1'b1, 8'h00);
        check(16'(rdata), 16'h0021);
        $display("test sleep done");
    endtask

    task automatic t_style();
        // non-zero strap codes 1 and 2 select direction-plus-enable
        for (int s = 1; s < 3; s++) begin
            rst_n   <= 1'b0;
            strap_a <= s[0];
            strap_b <= s[1];
            style = 1'b1;
            repeat (4) @(posedge clk);
            rst_n <= 1'b1;
            repeat (8) @(posedge clk);
            acc(1'b0, 1'b0, 8'h00);
            check(16'(rdata[6]), 16'h0001);
            cursor(16'h3000 + 16'(s));
            cmd(lhbp_pkg::CMD_MEM_WRITE);
            prm(8'h5A + 8'(s));
            cursor(16'h3000 + 16'(s));
            cmd(lhbp_pkg::CMD_MEM_READ);
            acc(1'b0, 1'b1, 8'h00);
            check(16'(rdata), 16'h005A + 16'(s));
        end
        $display("test bus style done");
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        t_status();
        t_dirs();
        t_read();
        t_fifo();
        t_sleep();
        t_style();
        conclude();
    end

    // the tests need about 2500 cycles
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        conclude();
    end
endmodule
